//--- hw/rcr_pkg.sv
// Shared constants and carriers for the reset cause recorder
package rcr_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] OFF_CAUSE    = 8'h00;  // Cause flags, service port
    localparam logic [7:0] OFF_CTRL     = 8'h04;  // Enable settings
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;  // Sticky event status
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h0c;  // Write one to clear
    localparam logic [7:0] OFF_IRQ_EN   = 8'h10;  // Interrupt enables
    localparam logic [7:0] OFF_WDOG_CNT = 8'h14;  // Live watchdog count

    // Cause flag positions
    localparam int BIT_POR     = 7;  // Power-on
    localparam int BIT_PIN     = 6;  // External reset pin
    localparam int BIT_WDOG    = 5;  // Watchdog
    localparam int BIT_BADOP   = 4;  // Bad opcode
    localparam int BIT_BADADDR = 3;  // Bad address
    localparam int BIT_OSC     = 2;  // Reference oscillator lost
    localparam int BIT_UV      = 1;  // Undervoltage

    // Cause value after power-on: power-on and undervoltage set
    localparam logic [7:0] CAUSE_POR_VALUE = 8'h82;

    // Watchdog service keys
    localparam logic [7:0] KEY_ARM  = 8'h55;
    localparam logic [7:0] KEY_FIRE = 8'haa;

    // Control field positions and reset value
    localparam int CTRL_WDOG_EN  = 0;
    localparam int CTRL_UVRST_EN = 1;
    localparam int CTRL_HALT_EN  = 2;
    localparam int CTRL_DBG_EN   = 3;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    // Interrupt status bit positions
    localparam int IRQ_RECORDED = 0;  // A reset cause was latched
    localparam int IRQ_SERVICED = 1;  // Watchdog restarted by key pair
    localparam int IRQ_W        = 2;

    // Timing counts in bus cycles
    localparam int RST_HOLD_CYCLES     = 16;
    localparam int WDOG_TIMEOUT_CYCLES = 8192;

    // Reset requests from logic on the bus clock
    typedef struct packed {
        logic badOpcode;   // Unimplemented or illegal opcode
        logic haltExec;    // Halt instruction executed
        logic debugExec;   // Enter-debug instruction executed
        logic badAddress;  // Access to unimplemented address
        logic oscLost;     // Reference clock monitor tripped
        logic debugForce;  // Debug host set force reset bit
    } rcr_src_s;

    // Control register layout
    typedef struct packed {
        logic dbgEn;    // Enter-debug instruction allowed
        logic haltEn;   // Halt instruction allowed
        logic uvRstEn;  // Undervoltage causes reset
        logic wdogEn;   // Watchdog running
    } rcr_ctrl_s;

endpackage : rcr_pkg

//--- hw/rcr_sync2.sv
`timescale 1ns/1ps
// Two flop synchroniser for asynchronous pin levels
module rcr_sync2 #(
    parameter int              WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clockEnable,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;  // First stage, read only by second

    // First stage feeds only the second stage to contain metastability
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_reg <= RESET_VALUE;
            dout     <= RESET_VALUE;
        end else if (clockEnable) begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end

endmodule : rcr_sync2

//--- hw/rcr_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: Cause flags are read-only; writes ignored
// R2: Debug forced reset leaves all flags clear
// R3: Bad key write resets while watchdog enabled
// R4: 0x55 then 0xAA restarts watchdog, flags kept
// R5: Power-on sets bit 7 and undervoltage
// R6: Enabled undervoltage trip resets, sets bit 1
// R7: Other resets record active sources only
// R8: External pin low level sets bit 6
// R9: Watchdog timeout sets bit 5 when enabled
// R10: Bad opcode sets bit 4
// R11: Halt instruction illegal when halt disabled
// R12: Enter-debug illegal when debug disabled
// R13: Bad address access sets bit 3
// R14: Oscillator loss sets bit 2
// R15: Bit 0 reserved, reads zero
// R16: Undervoltage keeps bit 7, clears others
module rcr_top #(
    parameter int WDOG_TIMEOUT = rcr_pkg::WDOG_TIMEOUT_CYCLES,
    parameter int RST_HOLD     = rcr_pkg::RST_HOLD_CYCLES
) (
    // Clock, power-on reset and freeze
    input  wire logic           clock,
    input  wire logic           reset,
    input  wire logic           clockEnable,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // Asynchronous pins
    input  wire logic           resetPinN,
    input  wire logic           lowVoltagePin,
    // Reset requests from core logic
    input  wire rcr_pkg::rcr_src_s cpuEvents,
    // System outputs
    output logic                sysReset,
    output logic                irq
);

    // Widths hold the terminal count
    localparam int CW = $clog2(WDOG_TIMEOUT + 1);  // Watchdog count width
    localparam int HW = $clog2(RST_HOLD + 1);      // Hold count width

    // Last values of both counters
    localparam logic [CW-1:0] WDOG_LAST = CW'(WDOG_TIMEOUT - 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(RST_HOLD - 1);

    // Local copy of the interrupt width
    localparam int IRQ_W_L = rcr_pkg::IRQ_W;

    // Sequencer states
    typedef enum logic [0:0] {
        RCR_RUN,   // Normal operation, sources watched
        RCR_HOLD   // System held in reset
    } rcr_state_e;

    // Sequencer and flags
    rcr_state_e        state_reg;      // Current sequencer state
    rcr_state_e        state_next;     // Next sequencer state
    logic [7:0]        cause_reg;      // Recorded cause flags
    logic [7:0]        cause_next;     // Flags latched at entry
    rcr_pkg::rcr_ctrl_s ctrl_reg;      // Enable settings

    // Counters and key arm
    logic [CW-1:0]     wdogCount_reg;  // Watchdog cycle count
    logic [CW-1:0]     wdogCount_next; // Watchdog count update
    logic [HW-1:0]     hold_reg;       // Reset hold countdown
    logic [HW-1:0]     hold_next;      // Countdown update
    logic              armed_reg;      // First service key seen
    logic              armed_next;     // Arm update

    // Interrupts and bus answer
    logic [IRQ_W_L-1:0] irqStat_reg;   // Sticky event bits
    logic [IRQ_W_L-1:0] irqStat_next;  // Status update
    logic [IRQ_W_L-1:0] irqEn_reg;     // Interrupt enables
    logic              ack_reg;        // Access phase ready
    logic [31:0]       prdata_reg;     // Captured read data

    // Synchronised pin levels
    logic [1:0] pinSync;    // {reset pin, undervoltage}
    logic       pinLow;     // External pin held low
    logic       uvLevel;    // Supply below trip level
    // Logic reads only stage two

    // Pins come from outside the clock domain
    // Reset value: pin released, supply good
    rcr_sync2 #(
        .WIDTH       (2),
        .RESET_VALUE (2'b10)
    ) u_pinSync (
        .clock       (clock),
        .reset       (reset),
        .clockEnable (clockEnable),
        .din         ({resetPinN, lowVoltagePin}),
        .dout        (pinSync)
    );

    assign pinLow  = ~pinSync[1];  // R8
    assign uvLevel = pinSync[0];

    // Bus decode
    logic access;      // Access phase under way
    logic busWrite;    // Write takes effect this edge
    logic capture;     // Read data captured this edge
    logic selCause;    // Cause register selected
    logic selCtrl;     // Control register selected
    logic selStat;     // Interrupt status selected
    logic selClr;      // Interrupt clear selected
    logic selEn;       // Interrupt enable selected
    logic selCnt;      // Watchdog count selected
    logic mapped;      // Address hits any register
    logic [7:0] wByte; // Low write byte

    // Phase strobes
    assign access   = psel & penable;
    assign capture  = access & ~ack_reg & clockEnable;
    assign busWrite = access & pwrite & pready;

    // Address decode
    assign selCause = (paddr == rcr_pkg::OFF_CAUSE);
    assign selCtrl  = (paddr == rcr_pkg::OFF_CTRL);
    assign selStat  = (paddr == rcr_pkg::OFF_IRQ_STAT);
    assign selClr   = (paddr == rcr_pkg::OFF_IRQ_CLR);
    assign selEn    = (paddr == rcr_pkg::OFF_IRQ_EN);
    assign selCnt   = (paddr == rcr_pkg::OFF_WDOG_CNT);
    assign mapped   = selCause | selCtrl | selStat | selClr | selEn
                    | selCnt;

    // Keys use the low byte only
    assign wByte    = pwdata[7:0];

    // One wait state; freeze also holds the answer off
    assign pready  = ack_reg & clockEnable;
    assign pslverr = pready & ~mapped;
    assign prdata  = prdata_reg;

    // Read mux; clear register reads as zero
    // Unmapped offsets read zero too
    logic [31:0] readData;
    assign readData =
        selCause ? {24'h0, cause_reg} :
        selCtrl  ? {28'h0, ctrl_reg} :
        selStat  ? {30'h0, irqStat_reg} :
        selEn    ? {30'h0, irqEn_reg} :
        selCnt   ? {{(32-CW){1'b0}}, wdogCount_reg} :
        32'h0;

    // Watchdog service port on the cause address
    logic keyWrite;    // Any write to cause address
    logic isArm;       // First key value
    logic isFire;      // Second key value
    logic restart;     // Valid key pair completed
    logic badKey;      // Value other than either key
    logic wdogTimeout; // Count reached its limit

    assign keyWrite = busWrite & selCause;
    assign isArm    = (wByte == rcr_pkg::KEY_ARM);
    assign isFire   = (wByte == rcr_pkg::KEY_FIRE);

    // Second key counts only when armed
    assign restart  = keyWrite & isFire & armed_reg;  // R4

    // Other values bite only when enabled
    assign badKey   = keyWrite & ~isArm & ~isFire
                    & ctrl_reg.wdogEn;  // R3

    // Entry takes one more edge
    assign wdogTimeout = ctrl_reg.wdogEn
                       & (wdogCount_reg == WDOG_LAST);  // R9

    // Reset source qualification
    logic wdogEv;   // Watchdog reset request
    logic badOpEv;  // Opcode reset request
    logic uvEv;     // Undervoltage reset request
    logic otherEv;  // Pin, watchdog, opcode or address
    logic anyEv;    // Any request
    logic entry;    // Reset entry this cycle

    assign wdogEv  = wdogTimeout | badKey;

    // Disallowed halt or debug is illegal
    assign badOpEv = cpuEvents.badOpcode
                   | (cpuEvents.haltExec & ~ctrl_reg.haltEn)   // R11
                   | (cpuEvents.debugExec & ~ctrl_reg.dbgEn);  // R12

    // Undervoltage resets only if enabled
    assign uvEv    = uvLevel & ctrl_reg.uvRstEn;  // R6
    assign otherEv = pinLow | wdogEv | badOpEv | cpuEvents.badAddress;
    assign anyEv   = uvEv | cpuEvents.oscLost | cpuEvents.debugForce
                   | otherEv;

    // Requests in hold are ignored
    assign entry   = (state_reg == RCR_RUN) & anyEv;

    // Flag sets for each kind of reset entry
    logic [7:0] uvCause;     // Undervoltage entry
    logic [7:0] oscCause;    // Oscillator loss entry
    logic [7:0] otherCause;  // Any other entry

    // Power-on flag kept, undervoltage set, rest clear
    assign uvCause = (cause_reg & 8'h80) | 8'h02;  // R16
    // Clock loss records only itself
    assign oscCause = 8'h04;  // R14
    // Only sources live at entry are recorded; bit 0 stays zero
    assign otherCause = {1'b0, pinLow, wdogEv, badOpEv,
                         cpuEvents.badAddress, 3'b000};  // R7 R10 R13 R15

    // One kind of entry recorded at a time
    // Undervoltage wins, then clock loss, then debug force
    assign cause_next =
        uvEv                 ? uvCause :
        cpuEvents.oscLost    ? oscCause :
        cpuEvents.debugForce ? 8'h00 :  // R2
        otherCause;

    // Sequencer: enter hold on any request, leave when quiet
    always_comb begin
        state_next = state_reg;
        hold_next  = hold_reg;
        case (state_reg)
            RCR_RUN: begin
                if (anyEv) begin
                    // Count down from the last value
                    state_next = RCR_HOLD;
                    hold_next  = HOLD_LAST;
                end
            end
            RCR_HOLD: begin
                // Level sources stretch the hold until released
                if (hold_reg != '0) begin
                    hold_next = hold_reg - HW'(1);
                end else if (~pinLow & ~uvEv) begin
                    state_next = RCR_RUN;
                end
            end
            default: begin
                // Unreachable; recover
                state_next = RCR_RUN;
            end
        endcase
    end

    // Output straight from the state flop
    assign sysReset = (state_reg == RCR_HOLD);

    // Watchdog count: cleared in hold, when disabled or serviced
    assign wdogCount_next =
        (sysReset | ~ctrl_reg.wdogEn | restart) ? '0 :
        wdogCount_reg + CW'(1);

    // Key sequencing: any other write to the cause address breaks the pair
    // A repeated arm key stays armed
    assign armed_next = sysReset ? 1'b0 :
                        keyWrite ? isArm :
                        armed_reg;

    // Sticky events; a new set wins over a same-cycle clear
    logic [IRQ_W_L-1:0] irqSet;  // Events this cycle
    logic [IRQ_W_L-1:0] irqClr;  // Clear mask written
    // Bit 1 serviced, bit 0 recorded
    assign irqSet = {restart, entry};
    // Clear only on a committed write
    assign irqClr = (busWrite & selClr) ? pwdata[IRQ_W_L-1:0] : '0;
    assign irqStat_next = (irqStat_reg & ~irqClr) | irqSet;

    // Level from enabled sticky bits
    assign irq = |(irqStat_reg & irqEn_reg);

    // Sequencer and cause flags; power-on loads the fixed value
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            // Power-on values
            state_reg <= RCR_RUN;
            hold_reg  <= '0;
            cause_reg <= rcr_pkg::CAUSE_POR_VALUE;  // R5
        end else if (clockEnable) begin
            state_reg <= state_next;
            hold_reg  <= hold_next;
            // Only entry loads flags, never the bus
            if (entry) begin
                cause_reg <= cause_next;  // R1
            end
        end
    end

    // Control settings return to defaults at every reset entry
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_reg <= rcr_pkg::CTRL_RESET;
        end else if (clockEnable) begin
            // Entry wins over a same-cycle write
            if (entry) begin
                ctrl_reg <= rcr_pkg::CTRL_RESET;
            end else if (busWrite & selCtrl) begin
                ctrl_reg <= pwdata[3:0];
            end
        end
    end

    // Watchdog counter and key arm flag
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            // Count starts from zero
            wdogCount_reg <= '0;
            armed_reg     <= 1'b0;
        end else if (clockEnable) begin
            wdogCount_reg <= wdogCount_next;
            armed_reg     <= armed_next;
        end
    end

    // Interrupt registers survive system resets so software sees them
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irqStat_reg <= '0;
            irqEn_reg   <= '0;
        end else if (clockEnable) begin
            irqStat_reg <= irqStat_next;
            // Enables change only by a write
            if (busWrite & selEn) begin
                irqEn_reg <= pwdata[IRQ_W_L-1:0];
            end
        end
    end

    // APB answer: capture data first, then ready for one cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_reg    <= 1'b0;
            prdata_reg <= '0;
        end else if (clockEnable) begin
            if (capture) begin
                ack_reg    <= 1'b1;
                // Writes load zero, no stale data
                prdata_reg <= pwrite ? 32'h0 : readData;
            end else if (pready) begin
                // Ready stands one enabled cycle
                ack_reg <= 1'b0;
            end
        end
    end

endmodule : rcr_top

//--- sim/rcr_properties.sv
`timescale 1ns/1ps
// Port-level watch on the reset cause recorder
module rcr_properties #(
    parameter int WDOG_TIMEOUT = 16,
    parameter int RST_HOLD     = 2
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              reset,
    input wire logic              clockEnable,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    // Sources and result
    input wire logic              resetPinN,
    input wire logic              lowVoltagePin,
    input wire rcr_pkg::rcr_src_s cpuEvents,
    input wire logic              sysReset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    wire       wr   = psel & penable & pready & pwrite;  // Write commit
    wire       key0 = wr && paddr == rcr_pkg::OFF_CAUSE; // Service write
    wire       run  = clockEnable && !sysReset;          // Requests taken
    logic [3:0] ctrlSh;                                  // Control shadow

    // Shadow of the control register; the reset hold (sysReset high) restores its reset value
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrlSh <= rcr_pkg::CTRL_RESET;
        end else if (sysReset) begin
            ctrlSh <= rcr_pkg::CTRL_RESET;
        end else if (wr && paddr == rcr_pkg::OFF_CTRL) begin
            ctrlSh <= pwdata[3:0];
        end
    end

    AST_BADKEY: assert property (key0 && ctrlSh[0] && !sysReset &&
        pwdata[7:0] != 8'h55 && pwdata[7:0] != 8'haa |=> sysReset)
        else $error("bad key write did not reset");
    AST_KEYPAIR: assert property (key0 && pwdata[7:0] == 8'haa &&
        !sysReset && cpuEvents == '0 && resetPinN && !lowVoltagePin
        |=> !sysReset) else $error("key pair caused a reset");
    AST_CAUSE_RD: assert property (pready && !pwrite &&
        paddr == rcr_pkg::OFF_CAUSE |-> prdata[0] == 1'b0 &&
        prdata[31:8] == 24'h0) else $error("cause reserved bits set");
    AST_BADOP: assert property (run && cpuEvents.badOpcode
        |=> sysReset) else $error("bad opcode did not reset");
    AST_HALT: assert property (run && cpuEvents.haltExec &&
        !ctrlSh[2] |=> sysReset) else $error("halt did not reset");
    AST_DEBUG: assert property (run && cpuEvents.debugExec &&
        !ctrlSh[3] |=> sysReset) else $error("debug did not reset");
    AST_BADADDR: assert property (run && cpuEvents.badAddress
        |=> sysReset) else $error("bad address did not reset");
    AST_OSC: assert property (run && cpuEvents.oscLost
        |=> sysReset) else $error("clock loss did not reset");
    AST_FORCE: assert property (run && cpuEvents.debugForce
        |=> sysReset) else $error("forced reset missing");
    AST_PIN: assert property ((!resetPinN && run)[*3]
        |-> ##[0:2] sysReset) else $error("pin low did not reset");
    AST_UV: assert property ((lowVoltagePin && ctrlSh[1] && run)[*3]
        |-> ##[0:2] sysReset) else $error("undervoltage no reset");
    AST_READY: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");

    // Main scenarios reached
    cover property ($rose(sysReset));
    cover property (key0 && pwdata[7:0] == 8'haa);
    cover property (run && cpuEvents.debugForce);
endmodule : rcr_properties

//--- sim/tb_rcr_top.sv
`timescale 1ns/1ps
// Self-checking bench for the reset cause recorder
module tb_rcr_top;
    // Design signals
    logic              clock, reset, clockEnable;
    logic              psel, penable, pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr;
    logic              resetPinN, lowVoltagePin;
    rcr_pkg::rcr_src_s cpuEvents;
    logic              sysReset, irq;
    // Bench state
    int                error_cnt = 0;
    int                total_checks = 0;
    int                seed = 32'h1974;
    logic [31:0]       rd, r;
    logic              err;
    logic [7:0]        cause;  // Expected cause flags
    logic [3:0]        ctl;    // Control value last written
    // Source, pin, undervoltage, control
    localparam logic [11:0] TBL [10] = '{12'h800, 12'h400, 12'h200,
        12'h100, 12'h080, 12'h040, 12'h020, 12'h012, 12'h920, 12'h0a0};

    rcr_top #(.WDOG_TIMEOUT(16), .RST_HOLD(2)) u_dut (
        .clock(clock), .reset(reset), .clockEnable(clockEnable),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .resetPinN(resetPinN),
        .lowVoltagePin(lowVoltagePin), .cpuEvents(cpuEvents),
        .sysReset(sysReset), .irq(irq));

    // 50 MHz bus clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Value and flag comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkb

    // One APB transfer; the spare leading edge keeps strobes single
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        chkb(pready, 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for the system reset level
    task automatic wait_rst(input logic v);
        for (int n = 0; n < 60; n++) begin
            @(negedge clock);
            if (sysReset === v) break;
        end
        chkb(sysReset, v);
    endtask : wait_rst

    // Cause expected from the sources at entry
    function automatic logic [7:0] exp_cause(input logic [5:0] s,
        input logic p, input logic u, input logic w);
        if (u && ctl[1]) return {cause[7], 7'h02};
        if (s[1]) return 8'h04;
        if (s[0]) return 8'h00;
        return {1'b0, p, w, s[5] | (s[4] & ~ctl[2]) | (s[3] & ~ctl[3]),
                s[2], 3'b000};
    endfunction : exp_cause

    // Raise sources or a key write, ride out the hold, read the cause
    task automatic evt(input logic [5:0] s, input logic p, input logic u,
                       input logic w, input logic [31:0] k);
        logic [7:0] exp;
        exp = exp_cause(s, p, u, w);
        @(posedge clock);
        resetPinN     <= ~p;
        lowVoltagePin <= u;
        // Core requests wait out the pin synchroniser
        repeat (2) @(posedge clock);
        cpuEvents     <= rcr_pkg::rcr_src_s'(s);
        if (k !== 32'h0) apb(1'b1, rcr_pkg::OFF_CAUSE, k);
        wait_rst(1'b1);
        @(posedge clock);
        cpuEvents     <= '0;
        resetPinN     <= 1'b1;
        lowVoltagePin <= 1'b0;
        wait_rst(1'b0);
        // Watchdog restarts enabled, so stop it before it bites
        apb(1'b1, rcr_pkg::OFF_CTRL, 32'h0);
        ctl = 4'h0;
        apb(1'b0, rcr_pkg::OFF_CAUSE, 32'h0);
        chk(rd, {24'h0, exp});
        cause = exp;
    endtask : evt

    // Verdict
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        clockEnable = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        resetPinN = 1'b1;
        lowVoltagePin = 1'b0;
        cpuEvents = '0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        apb(1'b1, rcr_pkg::OFF_CTRL, 32'h0);
        ctl = 4'h0;
        apb(1'b0, rcr_pkg::OFF_CAUSE, 32'h0);
        chk(rd, 32'h82);
        cause = 8'h82;
        apb(1'b1, rcr_pkg::OFF_CAUSE, 32'h12);
        @(negedge clock);
        chkb(sysReset, 1'b0);
        apb(1'b0, rcr_pkg::OFF_CAUSE, 32'h0);
        chk(rd, 32'h82);
        apb(1'b0, 8'h18, 32'h0);
        chkb(err, 1'b1);
        $display("test power-on done");
        apb(1'b1, rcr_pkg::OFF_CTRL, 32'h2);
        ctl = 4'h2;
        evt(6'h0, 1'b0, 1'b1, 1'b0, 32'h0);
        // Interrupt raised, masked, then cleared
        apb(1'b1, rcr_pkg::OFF_IRQ_EN, 32'h1);
        @(negedge clock);
        chkb(irq, 1'b1);
        apb(1'b1, rcr_pkg::OFF_IRQ_EN, 32'h0);
        @(negedge clock);
        chkb(irq, 1'b0);
        apb(1'b1, rcr_pkg::OFF_IRQ_EN, 32'h1);
        apb(1'b1, rcr_pkg::OFF_IRQ_CLR, 32'h3);
        @(negedge clock);
        chkb(irq, 1'b0);
        $display("test irq done");
        // Every source, alone and combined
        for (int i = 0; i < 10; i++) begin
            ctl = TBL[i][3:0];
            apb(1'b1, rcr_pkg::OFF_CTRL, {28'h0, ctl});
            evt(TBL[i][11:6], TBL[i][5], TBL[i][4], 1'b0, 32'h0);
        end
        // Halt and debug allowed by their enables
        apb(1'b1, rcr_pkg::OFF_CTRL, 32'hc);
        @(posedge clock);
        cpuEvents <= rcr_pkg::rcr_src_s'(6'h18);
        repeat (4) @(posedge clock);
        cpuEvents <= '0;
        @(negedge clock);
        chkb(sysReset, 1'b0);
        $display("test sources done");
        // Key pairs keep the watchdog quiet, then it times out
        apb(1'b1, rcr_pkg::OFF_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, rcr_pkg::OFF_CAUSE, 32'h55);
            if (i == 2) apb(1'b1, rcr_pkg::OFF_CAUSE, 32'h55);
            apb(1'b1, rcr_pkg::OFF_CAUSE, 32'haa);
            @(negedge clock);
            chkb(sysReset, 1'b0);
        end
        apb(1'b0, rcr_pkg::OFF_CAUSE, 32'h0);
        chk(rd, {24'h0, cause});
        apb(1'b0, rcr_pkg::OFF_IRQ_STAT, 32'h0);
        chk(rd, 32'h3);
        evt(6'h0, 1'b0, 1'b0, 1'b1, 32'h0);
        $display("test watchdog done");
        // Random bad keys and random source mixes
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            ctl = {r[17:16], 2'b00};
            apb(1'b1, rcr_pkg::OFF_CTRL, {28'h0, ctl[3:2], 1'b0, r[0]});
            if (r[0]) begin
                if (r[15:8] == 8'h55 || r[15:8] == 8'haa) r[15:8] = 8'h0;
                evt(6'h0, 1'b0, 1'b0, 1'b1, {8'h80, 16'h0, r[15:8]});
            end else begin
                if (exp_cause(r[13:8] & 6'h3c, r[14], 1'b0, 1'b0) == 0)
                    r[13] = 1'b1;
                evt(r[13:8] & 6'h3c, r[14], 1'b0, 1'b0, 32'h0);
            end
        end
        $display("test random done");
        tally_and_finish();
    end
endmodule : tb_rcr_top

bind rcr_top rcr_properties #(.WDOG_TIMEOUT(WDOG_TIMEOUT),
    .RST_HOLD(RST_HOLD)) u_props (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .resetPinN(resetPinN),
    .lowVoltagePin(lowVoltagePin), .cpuEvents(cpuEvents),
    .sysReset(sysReset));
